// >>> logic/pbcsr_phy_base_regs.sv
// phy base control and status register bank with event flags
`timescale 1ns/1ns
module pbcsr_phy_base_regs
  import pbcsr_pkg::*;
#(
  parameter int NUM_PORTS = 3
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [3:0] phyRegAddr,
  input wire logic [7:0] phyWriteData,
  input wire logic phyWriteStrobe,
  input wire logic phyReadStrobe,
  output logic [7:0] phyReadData,
  output logic phyReadValid,
  input wire logic contenderStrapPin,
  input wire logic [2:0] powerClassStrapPins,
  input wire logic cablePowerStatus,
  input wire logic linkAsleep,
  input wire logic loopDetected,
  input wire logic arbitrationTimeout,
  input wire logic shortResetIssued,
  input wire logic [NUM_PORTS-1:0] portConnected,
  input wire logic [NUM_PORTS-1:0] portBias,
  input wire logic [NUM_PORTS-1:0] portDisabled,
  input wire logic [NUM_PORTS-1:0] portFault,
  input wire logic [NUM_PORTS-1:0] portIntEnable,
  input wire logic [NUM_PORTS-1:0] portResumeStart,
  input wire logic resumeIntEnable,
  output logic selfIdContender,
  output logic [2:0] selfIdPowerClass,
  output logic shortResetRequest,
  output logic arbAccelEnable,
  output logic multiSpeedEnable,
  output logic [2:0] windowPage,
  output logic [3:0] windowPort,
  output logic linkInterrupt
);

  localparam int SNAP_W = 4 * NUM_PORTS;

  typedef struct packed {
    logic contenderSync1;
    logic contenderSync2;
    logic [2:0] powerClassSync1;
    logic [2:0] powerClassSync2;
    logic powerStatusSync1;
    logic powerStatusSync2;
    logic powerStatusPrev;
    logic [1:0] strapCount;
    logic contender;
    logic [2:0] powerClass;
    logic watchdog;
    logic shortReset;
    logic loop;
    logic powerFail;
    logic timeout;
    logic portEvent;
    logic accel;
    logic multi;
    logic [2:0] pageSelect;
    logic [3:0] portSelect;
    logic [SNAP_W-1:0] portSnapshot;
    logic [7:0] readData;
    logic readValid;
    logic interrupt;
  } pbcsr_state_type;

  pbcsr_state_type state;
  pbcsr_state_type next_state;

  logic [SNAP_W-1:0] portNow;
  logic [NUM_PORTS-1:0] portChanged;
  logic strapsLoaded;
  logic writeIntReg;
  logic anyResume;
  logic portEventSet;

  // per-port change detect, only ports with interrupt enable count
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : gPort
      assign portNow[4*g +: 4] = {portConnected[g], portBias[g], portDisabled[g], portFault[g]};
      assign portChanged[g] = portIntEnable[g]
                              & |(portNow[4*g +: 4] ^ state.portSnapshot[4*g +: 4]);
    end
  endgenerate

  assign strapsLoaded = (state.strapCount == PBCSR_STRAP_SETTLE_COUNT);
  assign writeIntReg = phyWriteStrobe & (phyRegAddr == PBCSR_ADDR_INTERRUPT_RESET);
  assign anyResume = |portResumeStart;
  assign portEventSet = (|portChanged) | (anyResume & resumeIntEnable);

  always_comb begin
    next_state = state;
    next_state.contenderSync1 = contenderStrapPin;
    next_state.contenderSync2 = state.contenderSync1;
    next_state.powerClassSync1 = powerClassStrapPins;
    next_state.powerClassSync2 = state.powerClassSync1;
    next_state.powerStatusSync1 = cablePowerStatus;
    next_state.powerStatusSync2 = state.powerStatusSync1;
    next_state.powerStatusPrev = state.powerStatusSync2;
    next_state.portSnapshot = portNow;
    if (!strapsLoaded) begin
      next_state.strapCount = state.strapCount + 2'h1;
      next_state.contender = state.contenderSync2;
      next_state.powerClass = state.powerClassSync2;
    end
    if (phyWriteStrobe && strapsLoaded && phyRegAddr == PBCSR_ADDR_POWER_CLASS_JITTER) begin
      next_state.contender = phyWriteData[PBCSR_CONTENDER_BIT];
      next_state.powerClass = phyWriteData[PBCSR_POWER_CLASS_LSB +: 3];
    end
    if (writeIntReg) begin
      next_state.watchdog = phyWriteData[PBCSR_WATCHDOG_BIT];
      next_state.accel = phyWriteData[PBCSR_ACCEL_BIT];
      next_state.multi = phyWriteData[PBCSR_MULTI_BIT];
      if (phyWriteData[PBCSR_LOOP_BIT]) next_state.loop = 1'b0;
      if (phyWriteData[PBCSR_POWER_FAIL_BIT]) next_state.powerFail = 1'b0;
      if (phyWriteData[PBCSR_TIMEOUT_BIT]) next_state.timeout = 1'b0;
      if (phyWriteData[PBCSR_PORT_EVENT_BIT]) next_state.portEvent = 1'b0;
    end
    // self-clear once issued; a new write wins
    if (shortResetIssued) next_state.shortReset = 1'b0;
    if (writeIntReg && phyWriteData[PBCSR_SHORT_RESET_BIT]) next_state.shortReset = 1'b1;
    // hardware set wins over a same-cycle clear
    if (loopDetected) next_state.loop = 1'b1;
    if (state.powerStatusPrev && !state.powerStatusSync2) next_state.powerFail = 1'b1;
    if (arbitrationTimeout) next_state.timeout = 1'b1;
    if (portEventSet) next_state.portEvent = 1'b1;
    if (phyWriteStrobe && phyRegAddr == PBCSR_ADDR_PAGE_PORT) begin
      next_state.pageSelect = phyWriteData[PBCSR_PAGE_SELECT_LSB +: 3];
      next_state.portSelect = phyWriteData[PBCSR_PORT_SELECT_LSB +: 4];
    end
    next_state.readValid = phyReadStrobe;
    next_state.readData = 8'h00;
    if (phyReadStrobe) begin
      unique case (phyRegAddr)
        PBCSR_ADDR_POWER_CLASS_JITTER: begin
          next_state.readData[PBCSR_POWER_CLASS_LSB +: 3] = state.powerClass;
          next_state.readData[PBCSR_JITTER_LSB +: 3] = PBCSR_JITTER_VALUE;
          next_state.readData[PBCSR_CONTENDER_BIT] = state.contender;
        end
        PBCSR_ADDR_INTERRUPT_RESET: begin
          next_state.readData[PBCSR_MULTI_BIT] = state.multi;
          next_state.readData[PBCSR_ACCEL_BIT] = state.accel;
          next_state.readData[PBCSR_PORT_EVENT_BIT] = state.portEvent;
          next_state.readData[PBCSR_TIMEOUT_BIT] = state.timeout;
          next_state.readData[PBCSR_POWER_FAIL_BIT] = state.powerFail;
          next_state.readData[PBCSR_LOOP_BIT] = state.loop;
          next_state.readData[PBCSR_SHORT_RESET_BIT] = state.shortReset;
          next_state.readData[PBCSR_WATCHDOG_BIT] = state.watchdog;
        end
        PBCSR_ADDR_PAGE_PORT: begin
          next_state.readData[PBCSR_PORT_SELECT_LSB +: 4] = state.portSelect;
          next_state.readData[PBCSR_PAGE_SELECT_LSB +: 3] = state.pageSelect;
        end
        // fields outside this bank and the paged window read zero here
        default: next_state.readData = 8'h00;
      endcase
    end
    next_state.interrupt = ((state.loop | state.powerFail | state.timeout)
                            & (~linkAsleep | state.watchdog))
                           | (anyResume & state.watchdog);
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= '0;
      state.powerFail <= PBCSR_RESET_POWER_FAIL;
      state.watchdog <= PBCSR_RESET_WATCHDOG;
      state.loop <= PBCSR_RESET_LOOP;
      state.timeout <= PBCSR_RESET_TIMEOUT;
      state.portEvent <= PBCSR_RESET_PORT_EVENT;
      state.accel <= PBCSR_RESET_ACCEL;
      state.multi <= PBCSR_RESET_MULTI;
      state.shortReset <= PBCSR_RESET_SHORT_RESET;
      state.pageSelect <= PBCSR_RESET_PAGE_SELECT;
      state.portSelect <= PBCSR_RESET_PORT_SELECT;
    end else begin
      state <= next_state;
    end
  end

  assign phyReadData = state.readData;
  assign phyReadValid = state.readValid;
  assign selfIdContender = state.contender;
  assign selfIdPowerClass = state.powerClass;
  assign shortResetRequest = state.shortReset;
  assign arbAccelEnable = state.accel;
  assign multiSpeedEnable = state.multi;
  assign windowPage = state.pageSelect;
  assign windowPort = state.portSelect;
  assign linkInterrupt = state.interrupt;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_intWrite(int b);
    writeIntReg && phyWriteData[b];
  endsequence

  sequence s_readInt;
    phyReadStrobe && phyRegAddr == PBCSR_ADDR_INTERRUPT_RESET;
  endsequence

  property p_jitterZero;
    phyReadStrobe && phyRegAddr == PBCSR_ADDR_POWER_CLASS_JITTER
      |=> phyReadValid && phyReadData[PBCSR_JITTER_LSB +: 3] == 3'h0;
  endproperty
  a_jitterZero: assert property (p_jitterZero) else $error("jitter not zero");

  property p_asleepGate;
    linkAsleep && !state.watchdog && !anyResume |=> !linkInterrupt;
  endproperty
  a_asleepGate: assert property (p_asleepGate) else $error("interrupt while asleep");

  property p_resumeIrq;
    anyResume && state.watchdog |=> linkInterrupt;
  endproperty
  a_resumeIrq: assert property (p_resumeIrq) else $error("resume interrupt missing");

  property p_shortReset;
    s_intWrite(PBCSR_SHORT_RESET_BIT) |=> shortResetRequest;
  endproperty
  a_shortReset: assert property (p_shortReset) else $error("short reset not raised");

  property p_shortResetClear;
    shortResetIssued && !(writeIntReg && phyWriteData[PBCSR_SHORT_RESET_BIT])
      |=> !shortResetRequest;
  endproperty
  a_shortResetClear: assert property (p_shortResetClear) else $error("no self clear");

  property p_loopClear;
    s_intWrite(PBCSR_LOOP_BIT) ##0 !loopDetected |=> !state.loop;
  endproperty
  a_loopClear: assert property (p_loopClear) else $error("loop not cleared");

  property p_powerFailSet;
    $fell(state.powerStatusSync2) |=> state.powerFail;
  endproperty
  a_powerFailSet: assert property (p_powerFailSet) else $error("power fail not set");

  property p_timeoutSet;
    arbitrationTimeout |=> state.timeout ##1 (s_readInt or 1'b1);
  endproperty
  a_timeoutSet: assert property (p_timeoutSet) else $error("timeout not set");

  property p_portEventSet;
    |portChanged |=> state.portEvent;
  endproperty
  a_portEventSet: assert property (p_portEventSet) else $error("port event missed");

  property p_resumeEvent;
    anyResume && resumeIntEnable |=> state.portEvent;
  endproperty
  a_resumeEvent: assert property (p_resumeEvent) else $error("resume event missed");

  property p_portEventClear;
    s_intWrite(PBCSR_PORT_EVENT_BIT) ##0 !portEventSet |=> !state.portEvent;
  endproperty
  a_portEventClear: assert property (p_portEventClear) else $error("port event stuck");

  property p_pageSelect;
    phyWriteStrobe && phyRegAddr == PBCSR_ADDR_PAGE_PORT
      |=> windowPage == $past(phyWriteData[2:0]) && windowPort == $past(phyWriteData[7:4]);
  endproperty
  a_pageSelect: assert property (p_pageSelect) else $error("selector not written");

  property p_contenderWrite;
    phyWriteStrobe && strapsLoaded && phyRegAddr == PBCSR_ADDR_POWER_CLASS_JITTER
      |=> selfIdContender == $past(phyWriteData[PBCSR_CONTENDER_BIT]);
  endproperty
  a_contenderWrite: assert property (p_contenderWrite) else $error("contender lost");

  property p_powerClassWrite;
    phyWriteStrobe && strapsLoaded && phyRegAddr == PBCSR_ADDR_POWER_CLASS_JITTER
      |=> selfIdPowerClass == $past(phyWriteData[PBCSR_POWER_CLASS_LSB +: 3]);
  endproperty
  a_powerClassWrite: assert property (p_powerClassWrite) else $error("power class lost");

  property p_watchdogWrite;
    writeIntReg |=> state.watchdog == $past(phyWriteData[PBCSR_WATCHDOG_BIT]);
  endproperty
  a_watchdogWrite: assert property (p_watchdogWrite) else $error("watchdog lost");

  property p_awakeIrq;
    (state.loop || state.powerFail || state.timeout) && !linkAsleep |=> linkInterrupt;
  endproperty
  a_awakeIrq: assert property (p_awakeIrq) else $error("awake interrupt missing");

  property p_shortResetHold;
    shortResetRequest && !shortResetIssued |=> shortResetRequest;
  endproperty
  a_shortResetHold: assert property (p_shortResetHold) else $error("short reset dropped");

  property p_loopSet;
    loopDetected |=> state.loop;
  endproperty
  a_loopSet: assert property (p_loopSet) else $error("loop not set");

  property p_powerFailClear;
    s_intWrite(PBCSR_POWER_FAIL_BIT) ##0 !(state.powerStatusPrev && !state.powerStatusSync2)
      |=> !state.powerFail;
  endproperty
  a_powerFailClear: assert property (p_powerFailClear) else $error("power fail stuck");

  property p_timeoutClear;
    s_intWrite(PBCSR_TIMEOUT_BIT) ##0 !arbitrationTimeout |=> !state.timeout;
  endproperty
  a_timeoutClear: assert property (p_timeoutClear) else $error("timeout stuck");

  property p_accelWrite;
    writeIntReg |=> arbAccelEnable == $past(phyWriteData[PBCSR_ACCEL_BIT]);
  endproperty
  a_accelWrite: assert property (p_accelWrite) else $error("accel not written");

  property p_multiWrite;
    writeIntReg |=> multiSpeedEnable == $past(phyWriteData[PBCSR_MULTI_BIT]);
  endproperty
  a_multiWrite: assert property (p_multiWrite) else $error("multi not written");

  property p_selectorRead;
    phyReadStrobe && phyRegAddr == PBCSR_ADDR_PAGE_PORT
      |=> phyReadData == {$past(windowPort), 1'b0, $past(windowPage)};
  endproperty
  a_selectorRead: assert property (p_selectorRead) else $error("selector read wrong");

endmodule : pbcsr_phy_base_regs

// >>> logic/pbcsr_pkg.sv
// constants of the phy base control and status registers
// Overview of operation
// - contender bit writable, reset from strap pin, drives self-id contender flag.
// - power class writable, reset from three straps, goes to self-id bits 21-23.
// - jitter field is read-only and reads zero, meaning 20ns variation.
// - asleep link gets loop, power-fail, timeout interrupts only with watchdog set.
// - watchdog bit also gates interrupt to link when any port starts resume.
// - writing one to short reset bit arbitrates, issues short reset, self-clears.
// - loop flag resets zero, cleared by writing one.
// - power fail flag resets one, set on power status falling, write-one clears.
// - timeout flag set on arbitration timeout, resets zero, write-one clears.
// - port event set when enabled port's connect, bias, disable or fault changes.
// - port event also set when resume begins and resume interrupt enabled.
// - port event resets zero, cleared by writing one.
// - acceleration enable bit resets zero and turns on enhanced arbitration.
// - page select resets 000, picks which of eight pages the window shows.
// - port select resets 0000, picks the port for per-port pages.
package pbcsr_pkg;
  localparam logic [3:0] PBCSR_ADDR_POWER_CLASS_JITTER = 4'h4;
  localparam logic [3:0] PBCSR_ADDR_INTERRUPT_RESET = 4'h5;
  localparam logic [3:0] PBCSR_ADDR_PAGE_PORT = 4'h7;
  localparam logic [3:0] PBCSR_ADDR_WINDOW_FIRST = 4'h8;
  // power_class_jitter_ctrl layout
  localparam int PBCSR_POWER_CLASS_LSB = 5;
  localparam int PBCSR_JITTER_LSB = 2;
  localparam int PBCSR_CONTENDER_BIT = 1;
  localparam logic [2:0] PBCSR_JITTER_VALUE = 3'h0;
  localparam int PBCSR_JITTER_NS = 20;
  // interrupt_and_reset_ctrl layout
  localparam int PBCSR_MULTI_BIT = 7;
  localparam int PBCSR_ACCEL_BIT = 6;
  localparam int PBCSR_PORT_EVENT_BIT = 5;
  localparam int PBCSR_TIMEOUT_BIT = 4;
  localparam int PBCSR_POWER_FAIL_BIT = 3;
  localparam int PBCSR_LOOP_BIT = 2;
  localparam int PBCSR_SHORT_RESET_BIT = 1;
  localparam int PBCSR_WATCHDOG_BIT = 0;
  // page_port_selector layout
  localparam int PBCSR_PORT_SELECT_LSB = 4;
  localparam int PBCSR_PAGE_SELECT_LSB = 0;
  // reset values
  localparam logic PBCSR_RESET_WATCHDOG = 1'b0;
  localparam logic PBCSR_RESET_LOOP = 1'b0;
  localparam logic PBCSR_RESET_POWER_FAIL = 1'b1;
  localparam logic PBCSR_RESET_TIMEOUT = 1'b0;
  localparam logic PBCSR_RESET_PORT_EVENT = 1'b0;
  localparam logic PBCSR_RESET_ACCEL = 1'b0;
  localparam logic PBCSR_RESET_MULTI = 1'b0;
  localparam logic PBCSR_RESET_SHORT_RESET = 1'b0;
  localparam logic [2:0] PBCSR_RESET_PAGE_SELECT = 3'h0;
  localparam logic [3:0] PBCSR_RESET_PORT_SELECT = 4'h0;
  // strap capture waits for the synchroniser to fill
  localparam logic [1:0] PBCSR_STRAP_SETTLE_COUNT = 2'h3;
endpackage : pbcsr_pkg

// >>> tb/pbcsr_link_model.sv
// link-side model that drives the phy register access port
`timescale 1ns/1ns
module pbcsr_link_model (
  input wire logic clock,
  output logic [3:0] phyRegAddr,
  output logic [7:0] phyWriteData,
  output logic phyWriteStrobe,
  output logic phyReadStrobe,
  input wire logic [7:0] phyReadData,
  input wire logic phyReadValid
);
  initial begin
    phyRegAddr = 4'h6;
    phyWriteData = 8'h5a;
    phyWriteStrobe = 1'b0;
    phyReadStrobe = 1'b0;
  end
  task automatic writeReg(input logic [3:0] addr, input logic [7:0] data);
    @(negedge clock);
    phyRegAddr = addr;
    phyWriteData = data;
    phyWriteStrobe = 1'b1;
    @(negedge clock);
    phyWriteStrobe = 1'b0;
    // idle bus shows junk, never the last value
    phyWriteData = ~data;
    phyRegAddr = ~addr;
  endtask : writeReg
  task automatic readReg(input logic [3:0] addr, output logic [7:0] data, output logic ok);
    @(negedge clock);
    phyRegAddr = addr;
    phyReadStrobe = 1'b1;
    @(negedge clock);
    phyReadStrobe = 1'b0;
    phyRegAddr = ~addr;
    ok = phyReadValid;
    data = phyReadData;
  endtask : readReg
endmodule : pbcsr_link_model

// >>> tb/pbcsr_phy_base_regs_tb.sv
// self-checking bench for the phy base register bank
`timescale 1ns/1ns
module pbcsr_phy_base_regs_tb;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [3:0] phyRegAddr;
  logic [7:0] phyWriteData;
  logic [7:0] phyReadData;
  logic phyWriteStrobe, phyReadStrobe, phyReadValid;
  logic contenderStrapPin = 1'b1;
  logic [2:0] powerClassStrapPins = 3'h5;
  logic cablePowerStatus = 1'b1;
  logic linkAsleep = 1'b0;
  logic loopDetected = 1'b0;
  logic arbitrationTimeout = 1'b0;
  logic shortResetIssued = 1'b0;
  logic [2:0] portConnected = 3'h0;
  logic [2:0] portBias = 3'h0;
  logic [2:0] portDisabled = 3'h0;
  logic [2:0] portFault = 3'h0;
  logic [2:0] portIntEnable = 3'h2;
  logic [2:0] portResumeStart = 3'h0;
  logic resumeIntEnable = 1'b1;
  logic selfIdContender, shortResetRequest, arbAccelEnable, multiSpeedEnable, linkInterrupt;
  logic [2:0] selfIdPowerClass;
  logic [2:0] windowPage;
  logic [3:0] windowPort;
  logic [7:0] rd;
  logic [2:0] m;
  logic ok, seen;
  int nMismatch = 0;
  int checkCount = 0;
  always #5 clock = ~clock;
  pbcsr_phy_base_regs #(.NUM_PORTS(3)) pbcsr_phy_base_regs_inst (.clock, .reset, .phyRegAddr,
    .phyWriteData, .phyWriteStrobe, .phyReadStrobe, .phyReadData, .phyReadValid,
    .contenderStrapPin, .powerClassStrapPins, .cablePowerStatus, .linkAsleep, .loopDetected,
    .arbitrationTimeout, .shortResetIssued, .portConnected, .portBias, .portDisabled,
    .portFault, .portIntEnable, .portResumeStart, .resumeIntEnable, .selfIdContender,
    .selfIdPowerClass, .shortResetRequest, .arbAccelEnable, .multiSpeedEnable, .windowPage,
    .windowPort, .linkInterrupt);
  pbcsr_link_model pbcsr_link_model_inst (.clock, .phyRegAddr, .phyWriteData,
    .phyWriteStrobe, .phyReadStrobe, .phyReadData, .phyReadValid);
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checkCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic rdChk(input logic [3:0] addr, input logic [7:0] exp);
    pbcsr_link_model_inst.readReg(addr, rd, ok);
    chk("read valid", 8'h01, {7'h0, ok});
    chk($sformatf("register %h", addr), exp, rd);
  endtask : rdChk
  task automatic wr(input logic [3:0] addr, input logic [7:0] data);
    pbcsr_link_model_inst.writeReg(addr, data);
  endtask : wr
  task automatic wrapUp;
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrapUp
  // hang guard, far above the real run length
  initial begin
    repeat (20000) @(posedge clock);
    nMismatch++;
    wrapUp();
  end
  initial begin
    repeat (5) @(posedge clock);
    @(negedge clock) reset = 1'b0;
    // straps settle before the first access
    repeat (6) @(negedge clock);
    rdChk(4'h4, 8'ha2);
    chk("contender", 8'h01, {7'h0, selfIdContender});
    chk("power class", 8'h05, {5'h0, selfIdPowerClass});
    rdChk(4'h5, 8'h08);
    rdChk(4'h7, 8'h00);
    rdChk(4'h6, 8'h00);
    chk("awake interrupt", 8'h01, {7'h0, linkInterrupt});
    wr(4'h4, 8'h1d);
    rdChk(4'h4, 8'h00);
    chk("self id", 8'h00, {4'h0, selfIdContender, selfIdPowerClass});
    wr(4'h5, 8'h08);
    rdChk(4'h5, 8'h00);
    chk("idle interrupt", 8'h00, {7'h0, linkInterrupt});
    linkAsleep = 1'b1;
    @(negedge clock) loopDetected = 1'b1;
    @(negedge clock) loopDetected = 1'b0;
    rdChk(4'h5, 8'h04);
    chk("asleep masked", 8'h00, {7'h0, linkInterrupt});
    wr(4'h5, 8'h01);
    @(negedge clock);
    chk("asleep watchdog", 8'h01, {7'h0, linkInterrupt});
    wr(4'h5, 8'h05);
    rdChk(4'h5, 8'h01);
    @(negedge clock) arbitrationTimeout = 1'b1;
    @(negedge clock) arbitrationTimeout = 1'b0;
    rdChk(4'h5, 8'h11);
    wr(4'h5, 8'h11);
    rdChk(4'h5, 8'h01);
    cablePowerStatus = 1'b0;
    repeat (6) @(negedge clock);
    rdChk(4'h5, 8'h09);
    wr(4'h5, 8'h09);
    // port 0 has its event enable off, port 1 on
    for (int k = 0; k < 8; k++) begin
      m = 3'h1 << (k / 4);
      @(negedge clock);
      case (k % 4)
        0: portConnected ^= m;
        1: portBias ^= m;
        2: portDisabled ^= m;
        default: portFault ^= m;
      endcase
      rdChk(4'h5, (k >= 4) ? 8'h21 : 8'h01);
      wr(4'h5, 8'h21);
    end
    rdChk(4'h5, 8'h01);
    for (int w = 1; w >= 0; w--) begin
      wr(4'h5, {7'h0, w[0]});
      seen = 1'b0;
      @(negedge clock) portResumeStart = 3'h4;
      @(negedge clock) portResumeStart = 3'h0;
      repeat (3) begin
        seen |= linkInterrupt;
        @(negedge clock);
      end
      chk("resume interrupt", {7'h0, w[0]}, {7'h0, seen});
      rdChk(4'h5, {3'h1, 4'h0, w[0]});
      wr(4'h5, 8'h20);
    end
    resumeIntEnable = 1'b0;
    @(negedge clock) portResumeStart = 3'h1;
    @(negedge clock) portResumeStart = 3'h0;
    rdChk(4'h5, 8'h00);
    wr(4'h5, 8'h02);
    chk("short reset held", 8'h01, {7'h0, shortResetRequest});
    rdChk(4'h5, 8'h02);
    @(negedge clock) shortResetIssued = 1'b1;
    @(negedge clock) shortResetIssued = 1'b0;
    rdChk(4'h5, 8'h00);
    chk("short reset done", 8'h00, {7'h0, shortResetRequest});
    wr(4'h5, 8'hc0);
    chk("accel multi", 8'h03, {6'h0, arbAccelEnable, multiSpeedEnable});
    rdChk(4'h5, 8'hc0);
    wr(4'h7, 8'hff);
    rdChk(4'h7, 8'hf7);
    chk("window", 8'h7f, {1'b0, windowPage, windowPort});
    wrapUp();
  end
endmodule : pbcsr_phy_base_regs_tb
